// ===== hw/lps_pkg.sv
`default_nettype none
package lps_pkg;

	// Clock and timing, times in ns
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROX_MEAS_NS = 540000;
	localparam int SLEEP_STEP_NS = 12500000;
	localparam int LIGHT_PERIOD_NS = 100000000;
	localparam int PROX_MEAS_CYC = PROX_MEAS_NS / CLK_PERIOD_NS;
	localparam int SLEEP_STEP_CYC = SLEEP_STEP_NS / CLK_PERIOD_NS;
	localparam int LIGHT_PERIOD_CYC = LIGHT_PERIOD_NS / CLK_PERIOD_NS;

	// Target write byte; the read byte is this with bit 0 set
	localparam logic [7:0] TARGET_WR_BYTE = 8'h88;

	// Register offsets
	localparam logic [7:0] REG_CFG = 8'h01;
	localparam logic [7:0] REG_EVT = 8'h02;
	localparam logic [7:0] REG_PLO = 8'h03;
	localparam logic [7:0] REG_PHI = 8'h04;
	localparam logic [7:0] REG_LLO = 8'h05;
	localparam logic [7:0] REG_LMID = 8'h06;
	localparam logic [7:0] REG_LHI = 8'h07;
	localparam logic [7:0] REG_PRES = 8'h08;
	localparam logic [7:0] REG_LRES_LO = 8'h09;
	localparam logic [7:0] REG_LRES_HI = 8'h0a;

	// Reset values
	localparam logic [7:0] CFG_RST = 8'hbc;
	localparam logic [7:0] EVT_RST = 8'h8b;
	localparam logic [7:0] PLO_RST = 8'h00;
	localparam logic [7:0] PHI_RST = 8'hff;
	localparam logic [7:0] LLO_RST = 8'h00;
	localparam logic [7:0] LMID_RST = 8'hf0;
	localparam logic [7:0] LHI_RST = 8'hff;

	// Field positions and masks of stored bits
	localparam int CFG_PROX_EN_BIT = 7;
	localparam int CFG_SLEEP_LSB = 4;
	localparam int CFG_DRIVE_BIT = 3;
	localparam int CFG_LIGHT_EN_BIT = 2;
	localparam logic [7:0] CFG_WMASK = 8'hfc;
	localparam int EVT_PFLAG_BIT = 7;
	localparam int EVT_PPERS_LSB = 5;
	localparam int EVT_LFLAG_BIT = 3;
	localparam int EVT_LPERS_LSB = 1;
	localparam int EVT_AND_BIT = 0;
	localparam logic [7:0] EVT_WMASK = 8'h67;

	// Persistence counter ceiling
	localparam logic [4:0] PERS_MAX = 5'h10;

	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} lps_req_s;

	typedef enum logic [2:0] {
		P_OFF = 3'b001,
		P_MEAS = 3'b010,
		P_SLEEP = 3'b100
	} lps_prox_e;

	typedef enum logic [8:0] {
		I_IDLE = 9'b000000001,
		I_ADDR = 9'b000000010,
		I_AACK = 9'b000000100,
		I_REG = 9'b000001000,
		I_RACK = 9'b000010000,
		I_WR = 9'b000100000,
		I_WACK = 9'b001000000,
		I_RD = 9'b010000000,
		I_MACK = 9'b100000000
	} lps_link_e;

	// Sleep length in 12.5 ms steps
	function automatic logic [6:0] sleep_steps(input logic [2:0] sel);
		case (sel)
			3'h7: sleep_steps = 7'h00;
			3'h6: sleep_steps = 7'h01;
			3'h5: sleep_steps = 7'h04;
			3'h4: sleep_steps = 7'h06;
			3'h3: sleep_steps = 7'h08;
			3'h2: sleep_steps = 7'h10;
			3'h1: sleep_steps = 7'h20;
			default: sleep_steps = 7'h40;
		endcase
	endfunction

	// Out-of-range results needed to raise a flag, except the light flag at setting 0, which is raised on every result
	function automatic logic [4:0] persist_need(input logic [1:0] sel);
		case (sel)
			2'h0: persist_need = 5'h01;
			2'h1: persist_need = 5'h04;
			2'h2: persist_need = 5'h08;
			default: persist_need = 5'h10;
		endcase
	endfunction

endpackage
`default_nettype wire

// ===== hw/lps_sensor_ctrl.sv
`default_nettype none
module lps_sensor_ctrl
	import lps_pkg::*;
#(
	parameter int PROX_MEAS_CYCLES = PROX_MEAS_CYC,
	parameter int SLEEP_STEP_CYCLES = SLEEP_STEP_CYC,
	parameter int LIGHT_PERIOD_CYCLES = LIGHT_PERIOD_CYC
)
(
	// System clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Converter samples from the analog front end
	input wire logic [7:0] prox_adc_in,
	input wire logic [11:0] light_adc_in,
	// Serial link
	input wire logic link_clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	// Emitter driver
	output logic emitter_driver_output_out,
	output logic emitter_drive_strength_out,
	// Open-drain event pin
	output logic event_pin_n_out,
	output logic event_pin_n_oe_n_out
);

	logic [7:0] cfg_q, evt_q, plo_q, phi_q, llo_q, lmid_q, lhi_q, pres_q;
	logic [11:0] lres_q;
	logic [7:0] prox_s1_q, prox_s2_q;
	logic [11:0] light_s1_q, light_s2_q;
	logic req_s1_q, req_s2_q, req_seen_q, ack_tgl_q;
	logic [7:0] rd_q;
	lps_req_s link_req_q;
	logic req_tgl_q;
	lps_prox_e p_state_q;
	logic [31:0] p_cnt_q, l_cnt_q, sleep_cyc;
	logic [4:0] ppc_q, lpc_q, ppc_d, lpc_d;
	logic req_new, wr_go, evt_wr, prox_post, light_post;
	logic prox_out, light_out, p_set, l_set, pin_low;
	logic [11:0] light_lo, light_hi;

	// Register readback, unmapped offsets read zero
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		case (a)
			REG_CFG: reg_read = cfg_q;
			REG_EVT: reg_read = evt_q;
			REG_PLO: reg_read = plo_q;
			REG_PHI: reg_read = phi_q;
			REG_LLO: reg_read = llo_q;
			REG_LMID: reg_read = lmid_q;
			REG_LHI: reg_read = lhi_q;
			REG_PRES: reg_read = pres_q;
			REG_LRES_LO: reg_read = lres_q[7:0];
			REG_LRES_HI: reg_read = {4'h0, lres_q[11:8]};
			default: reg_read = 8'h00;
		endcase
	endfunction

	// Front-end samples pass two flip-flops
	always_ff @(posedge sys_clk_in)
	begin
		if (ce_in)
		begin
			prox_s1_q <= prox_adc_in;
			prox_s2_q <= prox_s1_q;
			light_s1_q <= light_adc_in;
			light_s2_q <= light_s1_q;
		end
	end

	// Request toggle from the link side, two-flop synchroniser
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_seen_q <= 1'b0;
			ack_tgl_q <= 1'b0;
			rd_q <= 8'h00;
		end
		else if (ce_in)
		begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			if (req_new)
			begin
				req_seen_q <= req_s2_q;
				rd_q <= reg_read(link_req_q.addr);
				ack_tgl_q <= ~ack_tgl_q;
			end
		end
	end

	// Request payload is stable while its toggle is pending
	assign req_new = req_s2_q ^ req_seen_q;
	assign wr_go = ce_in & req_new & link_req_q.we;
	assign evt_wr = wr_go & (link_req_q.addr == REG_EVT);

	// Plain read-write registers
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			cfg_q <= CFG_RST;
			plo_q <= PLO_RST;
			phi_q <= PHI_RST;
			llo_q <= LLO_RST;
			lmid_q <= LMID_RST;
			lhi_q <= LHI_RST;
		end
		else if (wr_go)
		begin
			case (link_req_q.addr)
				REG_CFG: cfg_q <= link_req_q.data & CFG_WMASK;
				REG_PLO: plo_q <= link_req_q.data;
				REG_PHI: phi_q <= link_req_q.data;
				REG_LLO: llo_q <= link_req_q.data;
				REG_LMID: lmid_q <= link_req_q.data;
				REG_LHI: lhi_q <= link_req_q.data;
				default: ;
			endcase
		end
	end

	// Limits assembled from the split registers
	assign light_lo = {lmid_q[3:0], llo_q};
	assign light_hi = {lhi_q, lmid_q[7:4]};
	assign sleep_cyc = 32'(sleep_steps(cfg_q[CFG_SLEEP_LSB +: 3]))
		* 32'(SLEEP_STEP_CYCLES);

	// Proximity sequencer: measure, then sleep; at sleep setting 7 it measures back to back
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			p_state_q <= P_OFF;
			p_cnt_q <= 32'h0;
		end
		else if (ce_in)
		begin
			if (!cfg_q[CFG_PROX_EN_BIT])
			begin
				p_state_q <= P_OFF;
				p_cnt_q <= 32'h0;
			end
			else
			begin
				case (p_state_q)
					P_OFF:
					begin
						p_state_q <= P_MEAS;
						p_cnt_q <= 32'(PROX_MEAS_CYCLES - 1);
					end
					P_MEAS:
					begin
						if (p_cnt_q != 32'h0)
							p_cnt_q <= p_cnt_q - 32'h1;
						else if (sleep_cyc == 32'h0)
							p_cnt_q <= 32'(PROX_MEAS_CYCLES - 1);
						else
						begin
							p_state_q <= P_SLEEP;
							p_cnt_q <= sleep_cyc - 32'h1;
						end
					end
					P_SLEEP:
					begin
						if (p_cnt_q != 32'h0)
							p_cnt_q <= p_cnt_q - 32'h1;
						else
						begin
							p_state_q <= P_MEAS;
							p_cnt_q <= 32'(PROX_MEAS_CYCLES - 1);
						end
					end
					default:
					begin
						p_state_q <= P_OFF;
						p_cnt_q <= 32'h0;
					end
				endcase
			end
		end
	end

	// Result posting and out-of-range tests
	assign prox_post = ce_in & cfg_q[CFG_PROX_EN_BIT]
		& (p_state_q == P_MEAS) & (p_cnt_q == 32'h0);
	assign prox_out = (prox_s2_q < plo_q) | (prox_s2_q > phi_q);
	assign ppc_d = (ppc_q == PERS_MAX) ? PERS_MAX : ppc_q + 5'h1;
	assign p_set = prox_post & prox_out
		& (ppc_d >= persist_need(evt_q[EVT_PPERS_LSB +: 2]));

	// Light conversion period
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			l_cnt_q <= 32'h0;
		else if (ce_in)
		begin
			if (!cfg_q[CFG_LIGHT_EN_BIT] || light_post)
				l_cnt_q <= 32'h0;
			else
				l_cnt_q <= l_cnt_q + 32'h1;
		end
	end

	assign light_post = cfg_q[CFG_LIGHT_EN_BIT]
		& (l_cnt_q == 32'(LIGHT_PERIOD_CYCLES - 1));
	assign light_out = (light_s2_q < light_lo)
		| (light_s2_q > light_hi);
	assign lpc_d = (lpc_q == PERS_MAX) ? PERS_MAX : lpc_q + 5'h1;
	assign l_set = ce_in & light_post & ((evt_q[EVT_LPERS_LSB +: 2] == 2'h0)
		| (light_out & (lpc_d >= persist_need(evt_q[EVT_LPERS_LSB +: 2]))));

	// Results and consecutive out-of-range counters
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			pres_q <= 8'h00;
			lres_q <= 12'h000;
			ppc_q <= 5'h0;
			lpc_q <= 5'h0;
		end
		else if (ce_in)
		begin
			if (prox_post)
			begin
				pres_q <= prox_s2_q;
				ppc_q <= prox_out ? ppc_d : 5'h0;
			end
			if (light_post)
			begin
				lres_q <= light_s2_q;
				lpc_q <= light_out ? lpc_d : 5'h0;
			end
		end
	end

	// Event register; a set in the clearing cycle wins
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			evt_q <= EVT_RST;
		else if (ce_in)
		begin
			evt_q <= (evt_wr ? link_req_q.data : evt_q) & EVT_WMASK;
			evt_q[EVT_PFLAG_BIT] <= (evt_q[EVT_PFLAG_BIT]
				& ~(evt_wr & ~link_req_q.data[EVT_PFLAG_BIT])) | p_set;
			evt_q[EVT_LFLAG_BIT] <= (evt_q[EVT_LFLAG_BIT]
				& ~(evt_wr & ~link_req_q.data[EVT_LFLAG_BIT])) | l_set;
		end
	end

	assign pin_low = evt_q[EVT_AND_BIT]
		? (evt_q[EVT_PFLAG_BIT] & evt_q[EVT_LFLAG_BIT])
		: (evt_q[EVT_PFLAG_BIT] | evt_q[EVT_LFLAG_BIT]);

	// Pin and emitter outputs
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			event_pin_n_out <= 1'b1;
			event_pin_n_oe_n_out <= 1'b1;
			emitter_driver_output_out <= 1'b0;
			emitter_drive_strength_out <= 1'b0;
		end
		else if (ce_in)
		begin
			event_pin_n_out <= ~pin_low;
			event_pin_n_oe_n_out <= ~pin_low;
			emitter_driver_output_out <= (p_state_q == P_MEAS)
				& cfg_q[CFG_PROX_EN_BIT];
			emitter_drive_strength_out <= cfg_q[CFG_DRIVE_BIT];
		end
	end

	// Link domain
	logic lrst_s1_q, lrst_q, ack_s1_q, ack_s2_q, rw_q, mack_q;
	logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
	logic scl_rise, scl_fall, start_c, stop_c, hs_idle;
	lps_link_e l_state_q;
	logic [7:0] sh_q, tx_q, ptr_q;
	logic [3:0] bit_q;

	// Reset and acknowledge toggle pass two flip-flops, the pins three
	always_ff @(posedge link_clk_in)
	begin
		lrst_s1_q <= rst_in;
		lrst_q <= lrst_s1_q;
		scl_s1_q <= scl_in;
		scl_s2_q <= scl_s1_q;
		scl_s3_q <= scl_s2_q;
		sda_s1_q <= sda_in;
		sda_s2_q <= sda_s1_q;
		sda_s3_q <= sda_s2_q;
		ack_s1_q <= ack_tgl_q;
		ack_s2_q <= ack_s1_q;
	end

	assign scl_rise = scl_s2_q & ~scl_s3_q;
	assign scl_fall = ~scl_s2_q & scl_s3_q;
	assign start_c = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
	assign stop_c = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
	assign hs_idle = (ack_s2_q == req_tgl_q);

	// Target state machine; data released or pulled low only
	always_ff @(posedge link_clk_in)
	begin
		if (lrst_q)
		begin
			l_state_q <= I_IDLE;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			bit_q <= 4'h0;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
			sda_oe_n_out <= 1'b1;
			sda_out <= 1'b0; // Open drain: only ever pulls low
			req_tgl_q <= 1'b0;
			link_req_q <= '0;
		end
		else if (stop_c)
		begin
			l_state_q <= I_IDLE;
			sda_oe_n_out <= 1'b1;
		end
		else if (start_c)
		begin
			l_state_q <= I_ADDR;
			bit_q <= 4'h0;
			sda_oe_n_out <= 1'b1;
		end
		else
		begin
			case (l_state_q)
				I_ADDR, I_REG, I_WR:
				begin
					if (scl_rise)
					begin
						sh_q <= {sh_q[6:0], sda_s2_q};
						bit_q <= bit_q + 4'h1;
					end
					else if (scl_fall && bit_q == 4'h8)
					begin
						bit_q <= 4'h0;
						sda_oe_n_out <= 1'b0;
						if (l_state_q == I_ADDR)
						begin
							if (sh_q[7:1] == TARGET_WR_BYTE[7:1])
							begin
								l_state_q <= I_AACK;
								rw_q <= sh_q[0];
								if (sh_q[0] && hs_idle)
								begin
									link_req_q <= '{1'b0, ptr_q, 8'h00};
									req_tgl_q <= ~req_tgl_q;
								end
							end
							else
							begin
								l_state_q <= I_IDLE;
								sda_oe_n_out <= 1'b1;
							end
						end
						else if (l_state_q == I_REG)
						begin
							ptr_q <= sh_q;
							l_state_q <= I_RACK;
						end
						else
						begin
							if (hs_idle)
							begin
								link_req_q <= '{1'b1, ptr_q, sh_q};
								req_tgl_q <= ~req_tgl_q;
							end
							ptr_q <= ptr_q + 8'h1;
							l_state_q <= I_WACK;
						end
					end
				end
				I_AACK:
				begin
					if (scl_fall)
					begin
						bit_q <= 4'h0;
						if (rw_q)
						begin
							l_state_q <= I_RD;
							tx_q <= rd_q;
							sda_oe_n_out <= rd_q[7];
							if (hs_idle)
							begin
								link_req_q <= '{1'b0, ptr_q + 8'h1, 8'h00};
								req_tgl_q <= ~req_tgl_q;
							end
						end
						else
						begin
							l_state_q <= I_REG;
							sda_oe_n_out <= 1'b1;
						end
					end
				end
				I_RACK, I_WACK:
				begin
					if (scl_fall)
					begin
						l_state_q <= I_WR;
						bit_q <= 4'h0;
						sda_oe_n_out <= 1'b1;
					end
				end
				I_RD:
				begin
					if (scl_rise)
						bit_q <= bit_q + 4'h1;
					else if (scl_fall && bit_q == 4'h8)
					begin
						l_state_q <= I_MACK;
						sda_oe_n_out <= 1'b1;
					end
					else if (scl_fall)
					begin
						tx_q <= {tx_q[6:0], 1'b0};
						sda_oe_n_out <= tx_q[6];
					end
				end
				I_MACK:
				begin
					if (scl_rise)
						mack_q <= ~sda_s2_q;
					else if (scl_fall && mack_q)
					begin
						ptr_q <= ptr_q + 8'h1;
						tx_q <= rd_q;
						sda_oe_n_out <= rd_q[7];
						bit_q <= 4'h0;
						l_state_q <= I_RD;
						if (hs_idle)
						begin
							link_req_q <= '{1'b0, ptr_q + 8'h2, 8'h00};
							req_tgl_q <= ~req_tgl_q;
						end
					end
					else if (scl_fall)
						l_state_q <= I_IDLE;
				end
				default:
					l_state_q <= I_IDLE;
			endcase
		end
	end

	// Checks, system domain
	AST_PROX_OFF: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		ce_in && !cfg_q[CFG_PROX_EN_BIT] |=> p_state_q == P_OFF)
		else $error("proximity runs while disabled");
	AST_SLEEP_LOAD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		prox_post && sleep_cyc != 32'h0
		|=> p_state_q == P_SLEEP && p_cnt_q == $past(sleep_cyc) - 32'h1)
		else $error("sleep length not loaded");
	AST_DRIVE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		ce_in |=> emitter_drive_strength_out == $past(cfg_q[CFG_DRIVE_BIT]))
		else $error("drive strength does not follow its bit");
	AST_LIGHT_OFF: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		ce_in && !cfg_q[CFG_LIGHT_EN_BIT] |=> l_cnt_q == 32'h0 && !light_post)
		else $error("light measures while disabled");
	AST_PFLAG_HOLD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		evt_q[EVT_PFLAG_BIT] && !evt_wr |=> evt_q[EVT_PFLAG_BIT])
		else $error("proximity flag dropped without a write");
	AST_PPERSIST: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		prox_post && prox_out
		&& ppc_d >= persist_need(evt_q[EVT_PPERS_LSB +: 2])
		|=> evt_q[EVT_PFLAG_BIT])
		else $error("proximity flag not set at persistence count");
	AST_LFLAG_SET: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		l_set |=> evt_q[EVT_LFLAG_BIT])
		else $error("light flag not set");
	AST_PIN: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		ce_in |=> event_pin_n_oe_n_out == !$past(pin_low))
		else $error("event pin disagrees with flags");
	AST_PRES: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		prox_post |=> pres_q == $past(prox_s2_q))
		else $error("proximity result not posted");
	AST_PINRANGE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		prox_post && !prox_out |=> ppc_q == 5'h0)
		else $error("in-range result kept the count");

	// Checks, link domain
	AST_ADDR_MISS: assert property (@(posedge link_clk_in) disable iff (lrst_q)
		l_state_q == I_ADDR && scl_fall && bit_q == 4'h8 && !stop_c
		&& !start_c && sh_q[7:1] != TARGET_WR_BYTE[7:1]
		|=> l_state_q == I_IDLE && sda_oe_n_out)
		else $error("foreign address acknowledged");
	AST_PTR_INC: assert property (@(posedge link_clk_in) disable iff (lrst_q)
		l_state_q == I_WR && scl_fall && bit_q == 4'h8 && !stop_c
		&& !start_c |=> ptr_q == $past(ptr_q) + 8'h1 ##1 l_state_q == I_WACK)
		else $error("pointer not advanced after a data byte");

	COV_PROX_POST: cover property (@(posedge sys_clk_in) prox_post);
	COV_LFLAG: cover property (@(posedge sys_clk_in) l_set);
	COV_WRITE: cover property (@(posedge sys_clk_in) wr_go && evt_wr);
	COV_READ: cover property (@(posedge link_clk_in) l_state_q == I_MACK);

endmodule
`default_nettype wire

// ===== hw/lps_sensor_ctrl_unused.sv
`default_nettype none
`default_nettype wire

// ===== test/lps_i2c_host.sv
`default_nettype none
module lps_i2c_host
	import lps_pkg::*;
(
	// Wire level of the data line
	input wire logic sda_in,
	// Clock and data drive, 1 releases the line
	output logic scl_out,
	output logic sda_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// Low and high times of the bus clock
	localparam int TL = 1200;
	localparam int TH = 600;
	logic [7:0] rx_q [0:15];
	int nack_q;

	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
		nack_q = 0;
	end

	// Data changes only while the clock is low
	task automatic put_bit(input logic b);
		#(TL / 2) sda_out = b;
		#(TL / 2) scl_out = 1'b1;
		#TH scl_out = 1'b0;
	endtask

	// Release the line and sample it in mid high phase
	task automatic get_bit(output logic b);
		#(TL / 2) sda_out = 1'b1;
		#(TL / 2) scl_out = 1'b1;
		#(TH / 2) b = sda_in;
		#(TH / 2) scl_out = 1'b0;
	endtask

	// Start or repeated start: data falls while clock is high
	task automatic start();
		#(TL / 2) sda_out = 1'b1;
		#(TL / 2) scl_out = 1'b1;
		#TH sda_out = 1'b0;
		#TH scl_out = 1'b0;
	endtask

	// Stop: data rises while clock is high, both lines left released
	task automatic stop();
		#(TL / 2) sda_out = 1'b0;
		#(TL / 2) scl_out = 1'b1;
		#TH sda_out = 1'b1;
		#TH;
	endtask

	// Byte out MSB first; a missing acknowledge is counted
	task automatic send(input logic [7:0] b);
		logic a;
		for (int i = 7; i >= 0; i--)
			put_bit(b[i]);
		get_bit(a);
		if (a !== 1'b0)
			nack_q++;
	endtask

	// Pointer, then the low n bytes of d, the highest of them first
	task automatic wr(input logic [7:0] ptr, input int n,
		input logic [23:0] d);
		start();
		send(TARGET_WR_BYTE);
		send(ptr);
		for (int k = n - 1; k >= 0; k--)
			send(d[8 * k +: 8]);
		stop();
	endtask

	// Pointer, repeated start, n bytes read, the last one refused
	task automatic rd(input logic [7:0] ptr, input int n);
		logic b;
		start();
		send(TARGET_WR_BYTE);
		send(ptr);
		start();
		send(TARGET_WR_BYTE | 8'h01);
		for (int k = 0; k < n; k++)
		begin
			for (int i = 7; i >= 0; i--)
			begin
				get_bit(b);
				rx_q[k][i] = b;
			end
			put_bit(k == n - 1);
		end
		stop();
	endtask

	// Lone address byte, for a target that must stay silent
	task automatic probe(input logic [7:0] a);
		start();
		send(a);
		stop();
	endtask
endmodule
`default_nettype wire

// ===== test/lps_sensor_ctrl_tb.sv
`default_nettype none
module lps_sensor_ctrl_tb
	import lps_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// Shortened counts and run ceiling in system cycles
	localparam int PM = 20;
	localparam int SS = 10;
	localparam int LP = 50;
	localparam int LIMIT = 95000;
	logic sys_clk, link_clk, rst, ce, scl_h, sda_h, sda_w;
	logic sda_o, sda_oe_n, emit, drive, pin, pin_oe_n;
	logic [7:0] prox_adc;
	logic [11:0] light_adc;
	int n_fail, n_compared, cyc;

	// Wired-AND data line with pull-up
	assign sda_w = sda_h & (sda_oe_n | sda_o);

	lps_sensor_ctrl #(
		.PROX_MEAS_CYCLES(PM),
		.SLEEP_STEP_CYCLES(SS),
		.LIGHT_PERIOD_CYCLES(LP)
	) i_lps_sensor_ctrl (
		.sys_clk_in(sys_clk), .rst_in(rst), .ce_in(ce),
		.prox_adc_in(prox_adc), .light_adc_in(light_adc),
		.link_clk_in(link_clk), .scl_in(scl_h), .sda_in(sda_w),
		.sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
		.emitter_driver_output_out(emit),
		.emitter_drive_strength_out(drive),
		.event_pin_n_out(pin), .event_pin_n_oe_n_out(pin_oe_n)
	);

	lps_i2c_host i_lps_i2c_host (
		.sda_in(sda_w), .scl_out(scl_h), .sda_out(sda_h)
	);

	// Two unrelated clocks
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#3.3;
		forever #62.5 link_clk = ~link_clk;
	end

	// Cut a hang short
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			n_fail++;
			$display("[ERR] run length expected %0d seen %0d", LIMIT, cyc);
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [11:0] e,
		input logic [11:0] got);
		n_compared++;
		if (got !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, got);
		end
	endtask

	// Wait a bounded time for the pin enable to reach a level
	task automatic wait_pin(input logic lvl, input int max);
		int k;
		k = 0;
		while (pin_oe_n !== lvl && k < max)
		begin
			@(negedge sys_clk);
			k++;
		end
		chk("event pin enable", {11'h0, lvl}, {11'h0, pin_oe_n});
		chk("event pin level", {11'h0, lvl}, {11'h0, pin});
	endtask

	// Cycles for which the emitter window stays at a level
	task automatic run_len(input logic lvl, output int n);
		n = 0;
		while (emit === lvl && n < 400)
		begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	// Read n registers and compare them with the low n bytes of e, highest first
	task automatic rd_chk(input logic [7:0] ptr, input int n,
		input logic [79:0] e);
		i_lps_i2c_host.rd(ptr, n);
		for (int k = 0; k < n; k++)
			chk($sformatf("reg %h", ptr + k), {4'h0, e[8 * (n - 1 - k) +: 8]},
				{4'h0, i_lps_i2c_host.rx_q[k]});
	endtask

	task automatic t_reset();
		int hi, lo;
		wait_pin(1'b0, 3);
		chk("drive strength", 12'h1, {11'h0, drive});
		run_len(1'b1, hi);
		run_len(1'b0, lo);
		run_len(1'b1, hi);
		run_len(1'b0, lo);
		chk("emitter window", PM, hi[11:0]);
		chk("emitter sleep", SS * 8, lo[11:0]);
		// Clock enable low freezes the sequencer and its outputs
		ce = 1'b0;
		hi = 0;
		lo = emit;
		repeat (PM + SS * 8)
		begin
			@(negedge sys_clk);
			if (emit !== lo[0])
				hi++;
		end
		ce = 1'b1;
		chk("emitter while frozen", 12'h0, hi[11:0]);
		rd_chk(REG_CFG, 10, {CFG_RST, EVT_RST, PLO_RST, PHI_RST, LLO_RST,
			LMID_RST, LHI_RST, 8'h5a, 8'hc7, 8'h03});
		$display("t_reset done");
	endtask

	task automatic t_clear();
		i_lps_i2c_host.wr(REG_EVT, 1, 24'h02);
		wait_pin(1'b1, 20);
		$display("t_clear done");
	endtask

	task automatic t_prox();
		i_lps_i2c_host.wr(REG_PLO, 1, 24'h60);
		wait_pin(1'b0, 150);
		rd_chk(REG_EVT, 2, 80'h8260);
		$display("t_prox done");
	endtask

	task automatic t_light();
		i_lps_i2c_host.wr(REG_EVT, 1, 24'h83);
		wait_pin(1'b1, 20);
		i_lps_i2c_host.wr(REG_LLO, 3, 24'h00f080);
		@(negedge sys_clk);
		light_adc = 12'h80f;
		repeat (4 * LP) @(negedge sys_clk);
		wait_pin(1'b1, 0);
		light_adc = 12'h810;
		repeat (3 * LP) @(negedge sys_clk);
		wait_pin(1'b1, 0);
		wait_pin(1'b0, 2 * LP);
		rd_chk(REG_EVT, 1, 80'h8b);
		$display("t_light done");
	endtask

	task automatic t_misc();
		int hi;
		hi = i_lps_i2c_host.nack_q;
		chk("missing acks", 12'h0, hi[11:0]);
		i_lps_i2c_host.probe(8'h90);
		hi = i_lps_i2c_host.nack_q;
		chk("foreign address acks", 12'h1, hi[11:0]);
		i_lps_i2c_host.wr(REG_CFG, 1, 24'h00);
		@(negedge sys_clk);
		prox_adc = 8'h11;
		light_adc = 12'h123;
		chk("drive strength", 12'h0, {11'h0, drive});
		hi = 0;
		repeat (300)
		begin
			@(negedge sys_clk);
			if (emit !== 1'b0)
				hi++;
		end
		chk("emitter while off", 12'h0, hi[11:0]);
		rd_chk(REG_PRES, 3, 80'h5a1008);
		$display("t_misc done");
	endtask

	// Main sequence
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		prox_adc = 8'h5a;
		light_adc = 12'h3c7;
		n_fail = 0;
		n_compared = 0;
		repeat (20) @(negedge link_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		t_reset();
		t_clear();
		t_prox();
		t_light();
		t_misc();
		end_of_test();
	end
endmodule
`default_nettype wire
